// >>> hdl/oscms_top.sv
`timescale 1ns/1ps
module oscms_top
    import oscms_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    // Configuration loader
    input  wire logic                   cfg_clk_bits_valid,
    input  wire logic                   cfg_freq_given,
    input  wire logic [OSCMS_SEL_W-1:0] cfg_freq_sel,
    input  wire logic                   cfg_osc_enable,
    // User logic
    input  wire logic                   user_osc_enable,
    // Oscillator control and status
    output logic [OSCMS_SEL_W-1:0]      osc_freq_sel,
    output logic [OSCMS_KHZ_W-1:0]      osc_freq_khz,
    output logic                        osc_run,
    output logic                        osc_to_clock_tree,
    output logic                        osc_to_pll_ref,
    output logic                        cfg_clk_done
);

    // ****************************************************
    // Types
    // ****************************************************
    // One-hot load sequence: waiting for bits, then frozen
    typedef enum logic [1:0]
    {
        OSCMS_LD_WAIT = 2'h1,
        OSCMS_LD_DONE = 2'h2
    } oscms_load_t;

    // ****************************************************
    // Declarations
    // ****************************************************
    // User enable synchroniser
    logic                         user_en_meta_reg;
    logic                         user_en_meta_next;
    logic                         user_en_sync_reg;
    logic                         user_en_sync_next;

    // Load sequence
    oscms_load_t                  load_state_reg;
    oscms_load_t                  load_state_next;
    wire  logic                   in_wait;
    wire  logic                   in_done;
    wire  logic                   load_now;

    // Frequency selection
    logic [OSCMS_SEL_W-1:0]       sel_reg;
    logic [OSCMS_SEL_W-1:0]       sel_next;
    wire  logic [OSCMS_SEL_W-1:0] sel_checked;
    wire  logic [OSCMS_SEL_W-1:0] sel_loaded;

    // Nominal frequency
    logic [OSCMS_KHZ_W-1:0]       khz_reg;
    logic [OSCMS_KHZ_W-1:0]       khz_next;
    wire  logic [OSCMS_KHZ_W-1:0] khz_loaded;

    // Enable path
    logic                         cfg_en_reg;
    logic                         cfg_en_next;
    wire  logic                   cfg_off;
    wire  logic                   user_off;
    wire  logic                   run_w;

    // ****************************************************
    // Input synchroniser
    // ****************************************************
    // User enable is asynchronous to clk_sys
    assign user_en_meta_next = user_osc_enable;
    assign user_en_sync_next = user_en_meta_reg;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            user_en_meta_reg <= OSCMS_SYNC_RST;
        end
        else
        begin
            user_en_meta_reg <= user_en_meta_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            user_en_sync_reg <= OSCMS_SYNC_RST;
        end
        else
        begin
            user_en_sync_reg <= user_en_sync_next;
        end
    end

    // ****************************************************
    // Load sequence
    // ****************************************************
    assign in_wait  = (load_state_reg == OSCMS_LD_WAIT);
    assign in_done  = (load_state_reg == OSCMS_LD_DONE);
    // Only the first valid cycle after reset is taken
    assign load_now = in_wait && cfg_clk_bits_valid;

    // Later loads are ignored until the next reset
    always_comb
    begin
        load_state_next = load_state_reg;
        unique case (load_state_reg)
            OSCMS_LD_WAIT:
            begin
                if (cfg_clk_bits_valid)
                begin
                    load_state_next = OSCMS_LD_DONE;
                end
            end
            OSCMS_LD_DONE:
            begin
                load_state_next = OSCMS_LD_DONE;
            end
            default:
            begin
                load_state_next = OSCMS_LD_WAIT;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            load_state_reg <= OSCMS_LD_WAIT;
        end
        else
        begin
            load_state_reg <= load_state_next;
        end
    end

    // ****************************************************
    // Frequency selection
    // ****************************************************
    // Out-of-table codes fall back to the default
    assign sel_checked = oscms_legal(cfg_freq_sel);
    // No selection in the bitstream keeps the default
    assign sel_loaded  = cfg_freq_given ? sel_checked
                                        : OSCMS_SEL_DFLT;
    assign sel_next    = load_now ? sel_loaded : sel_reg;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_reg <= OSCMS_SEL_DFLT;
        end
        else
        begin
            sel_reg <= sel_next;
        end
    end

    // ****************************************************
    // Nominal frequency
    // ****************************************************
    // Looked up at load time so the output comes from a flop
    assign khz_loaded = oscms_khz(sel_loaded);
    assign khz_next   = load_now ? khz_loaded : khz_reg;

    // Reset value matches the default code
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            khz_reg <= OSCMS_KHZ_DFLT;
        end
        else
        begin
            khz_reg <= khz_next;
        end
    end

    // ****************************************************
    // Enable path
    // ****************************************************
    // Configuration enable is assumed on until loaded
    assign cfg_en_next = load_now ? cfg_osc_enable : cfg_en_reg;
    assign cfg_off     = !cfg_en_reg;
    // Synchronised user enable, two cycles late
    assign user_off    = !user_en_sync_reg;
    // Either control alone stops the oscillator
    assign run_w       = !(cfg_off || user_off);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_en_reg <= OSCMS_CFG_EN_RST;
        end
        else
        begin
            cfg_en_reg <= cfg_en_next;
        end
    end

    // ****************************************************
    // Outputs
    // ****************************************************
    // Status
    assign osc_freq_sel      = sel_reg;
    assign osc_freq_khz      = khz_reg;
    assign cfg_clk_done      = in_done;

    // Clock gating: same gate feeds tree and PLL reference
    assign osc_run           = run_w;
    assign osc_to_clock_tree = run_w;
    assign osc_to_pll_ref    = run_w;

endmodule

// >>> common/oscms_pkg.sv
package oscms_pkg;

    // ****************************************************
    // Frequency table
    // ****************************************************
    localparam int          OSCMS_NUM_FREQ  = 21;
    localparam int          OSCMS_SEL_W     = 5;
    localparam int          OSCMS_KHZ_W     = 18;
    localparam logic [4:0]  OSCMS_SEL_DFLT  = 5'h00;
    localparam logic [4:0]  OSCMS_SEL_MAX   = 5'h14;

    // ****************************************************
    // Reset values
    // ****************************************************
    localparam logic        OSCMS_SYNC_RST   = 1'b0;
    localparam logic        OSCMS_CFG_EN_RST = 1'b1;
    localparam logic [17:0] OSCMS_KHZ_DFLT   = 18'h00820;

    // Nominal frequency of each code, in kHz
    function automatic logic [17:0] oscms_khz(input logic [4:0] sel);
        logic [17:0] f;
        f = 18'h00820;
        unique case (sel)
            5'h00: f = 18'd2080;
            5'h01: f = 18'd2460;
            5'h02: f = 18'd3170;
            5'h03: f = 18'd4290;
            5'h04: f = 18'd5540;
            5'h05: f = 18'd7000;
            5'h06: f = 18'd8310;
            5'h07: f = 18'd9170;
            5'h08: f = 18'd10230;
            5'h09: f = 18'd13300;
            5'h0a: f = 18'd14780;
            5'h0b: f = 18'd20460;
            5'h0c: f = 18'd26600;
            5'h0d: f = 18'd29560;
            5'h0e: f = 18'd33250;
            5'h0f: f = 18'd38000;
            5'h10: f = 18'd44330;
            5'h11: f = 18'd53200;
            5'h12: f = 18'd66500;
            5'h13: f = 18'd88670;
            5'h14: f = 18'd133000;
            default: f = 18'd2080;
        endcase
        return f;
    endfunction

    // Codes beyond the table fall back to the default
    function automatic logic [4:0] oscms_legal(input logic [4:0] sel);
        return (sel > OSCMS_SEL_MAX) ? OSCMS_SEL_DFLT : sel;
    endfunction

endpackage

// >>> tb/oscms_top_asserts.sv
`timescale 1ns/1ps
module oscms_top_asserts (
    input wire logic        clk_sys, rst_n, cfg_clk_bits_valid,
    input wire logic        cfg_freq_given, cfg_osc_enable, user_osc_enable,
    input wire logic        osc_run, osc_to_clock_tree, osc_to_pll_ref,
    input wire logic        cfg_clk_done,
    input wire logic [4:0]  cfg_freq_sel, osc_freq_sel,
    input wire logic [17:0] osc_freq_khz
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire ld = cfg_clk_bits_valid && !cfg_clk_done;
    a_done_set: assert property (ld |=> cfg_clk_done)
        else $error("load not marked done");
    a_sel_take: assert property (
        ld && cfg_freq_given && cfg_freq_sel <= 5'h14
        |=> osc_freq_sel == $past(cfg_freq_sel))
        else $error("selected index not taken");
    a_sel_none: assert property (
        ld && !cfg_freq_given |=> osc_freq_sel == 5'h00)
        else $error("default lost without selection");
    a_khz_dflt: assert property (
        !cfg_clk_done |-> osc_freq_khz == 18'd2080)
        else $error("frequency moved before load");
    a_sel_dflt: assert property (!cfg_clk_done |-> osc_freq_sel == 5'h00)
        else $error("index moved before load");
    a_sel_stand: assert property (cfg_clk_done |=> $stable(osc_freq_sel))
        else $error("index changed after load");
    a_fan_out: assert property (
        osc_to_clock_tree == osc_run && osc_to_pll_ref == osc_run)
        else $error("tree or reference differs from run");
    a_user_off: assert property (!user_osc_enable [*3] |-> !osc_run)
        else $error("user disable ignored");
    a_cfg_off: assert property (ld && !cfg_osc_enable |=> !osc_run [*4])
        else $error("config disable ignored");
    c_load: cover property (ld && cfg_freq_given);
    c_top: cover property (cfg_clk_done && osc_freq_sel == 5'h14);
    c_run: cover property (cfg_clk_done && osc_run);
endmodule
bind oscms_top oscms_top_asserts i_chk (.*);

// >>> tb/oscms_loader.sv
`timescale 1ns/1ps
module oscms_loader (
    input  wire logic       clk_sys, go, osc_to_clock_tree,
    input  wire logic [6:0] pick,
    output logic            cfg_clk_bits_valid, cfg_freq_given,
    output logic            cfg_osc_enable,
    output logic [4:0]      cfg_freq_sel,
    output logic [3:0]      fab_div
);
    logic [6:0] q = 7'h00;
    logic [3:0] div_q = 4'h0;
    assign fab_div = div_q;
    // Fabric consumer divides the gated oscillator clock
    always @(posedge clk_sys)
        div_q <= osc_to_clock_tree ? 4'(div_q + 4'h1) : div_q;
    assign {cfg_freq_given, cfg_osc_enable, cfg_freq_sel} = q;
    // Fields invert when no frame is on them
    always_ff @(posedge clk_sys)
    begin
        cfg_clk_bits_valid <= go;
        q <= go ? pick : ~q;
    end
endmodule

// >>> tb/test_oscms_top.sv
`timescale 1ns/1ps
module test_oscms_top;
    logic        clk_sys = 1'b0, rst_n = 1'b0, go = 1'b0;
    logic        user_osc_enable = 1'b1;
    logic [6:0]  pick = 7'h00;
    logic        cfg_clk_bits_valid, cfg_freq_given, cfg_osc_enable, osc_run;
    logic        osc_to_clock_tree, osc_to_pll_ref, cfg_clk_done;
    logic [4:0]  cfg_freq_sel, osc_freq_sel;
    logic [17:0] osc_freq_khz;
    logic [3:0]  fab_div;
    int          errors = 0, compares = 0;
    always #25 clk_sys = ~clk_sys;
    oscms_loader i_ldr (.*);
    oscms_top i_dut (.*);
    task chk(input logic [17:0] got, input logic [17:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task print_verdict;
        if (errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task t_load(input logic [6:0] p, input logic [4:0] s,
                input logic [17:0] k, input logic r, u);
        logic [3:0] d0;
        @(posedge clk_sys);
        rst_n <= 1'b0;
        user_osc_enable <= u;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        go <= 1'b1;
        pick <= p;
        @(negedge clk_sys) chk(osc_freq_khz, 18'd2080);
        @(posedge clk_sys) go <= 1'b0;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys) chk(osc_freq_khz, k);
        chk(osc_freq_sel, s);
        @(posedge clk_sys) go <= 1'b1;
        pick <= 7'h74;
        @(posedge clk_sys) go <= 1'b0;
        repeat (3) @(negedge clk_sys);
        chk(osc_freq_khz, k);
        chk(osc_freq_sel, s);
        chk({cfg_clk_done, osc_run, osc_to_clock_tree, osc_to_pll_ref}, {1'b1, r, r, r});
        d0 = fab_div;
        @(negedge clk_sys) chk(fab_div, r ? 4'(d0 + 4'h1) : d0);
    endtask
    initial
    begin
        t_load(7'h67, 5'h07, 18'd9170, 1'b1, 1'b1);
        t_load(7'h25, 5'h00, 18'd2080, 1'b1, 1'b1);
        t_load(7'h74, 5'h14, 18'd133000, 1'b1, 1'b1);
        t_load(7'h75, 5'h00, 18'd2080, 1'b1, 1'b1);
        t_load(7'h4e, 5'h0e, 18'd33250, 1'b0, 1'b1);
        t_load(7'h73, 5'h13, 18'd88670, 1'b0, 1'b0);
        print_verdict;
    end
    initial
    begin
        #20000;
        errors++;
        print_verdict;
    end
endmodule
